/* drs_defs.svh */
// offsets, field positions and counts of the driver status readback block
`ifndef DRS_DEFS_SVH
`define DRS_DEFS_SVH

`define DRS_ADDR_W 7
`define DRS_OFS_CLK_SUP 7'h0b
`define DRS_OFS_SEC_ID 7'h10
`define DRS_OFS_SEC_STAT 7'h11

`define DRS_RST_CLK_SUP 16'h0001
`define DRS_RST_SEC_STAT 16'h0001

`define DRS_BIT_PAR 0
`define DRS_BIT_MSG_INV 1
`define DRS_CS_LSB 8
`define DRS_CS_W 8
`define DRS_VER_LSB 4
`define DRS_VER_W 12
`define DRS_BIT_OVERTEMP 13
`define DRS_BIT_TRISTATE 12
`define DRS_BIT_OCP 11
`define DRS_BIT_DEBUG 10
`define DRS_MODE_LSB 7
`define DRS_MODE_W 3
`define DRS_BIT_CLASS_B 6
`define DRS_BIT_CLASS_A 5
`define DRS_BIT_PWM 4

// status pin vector order
`define DRS_PIN_OVERTEMP 0
`define DRS_PIN_TRISTATE 1
`define DRS_PIN_OCP 2
`define DRS_PIN_DEBUG 3
`define DRS_PIN_CLASS_B 4
`define DRS_PIN_CLASS_A 5
`define DRS_PIN_PWM 6
`define DRS_PIN_N 7

// supervision measurement window in clk cycles
`define DRS_SUP_WINDOW_CYC 256
`define DRS_SUP_WIN_W 16

`endif

/* drs_pkg.sv */
// types of the driver status readback block
`default_nettype none
package drs_pkg;
	typedef enum logic [2:0] {
		DRS_SUP_IDLE = 3'b001,
		DRS_SUP_COUNT = 3'b010,
		DRS_SUP_STORE = 3'b100
	} drs_sup_state_type;

	typedef logic [6:0] drs_addr_type;
	typedef logic [15:0] drs_word_type;
endpackage
`default_nettype wire

/* drs_clock_check.sv */
// primary oscillator supervision counter
`timescale 1ns/1ns
`default_nettype none
`include "drs_defs.svh"
module drs_clock_check #(
	parameter int WINDOW_CYC = `DRS_SUP_WINDOW_CYC
)(
	input wire logic clk, // system clock
	input wire logic sys_rst, // async reset, active high
	input wire logic primary_oscillator, // raw oscillator pin
	input wire logic primary_count_clear, // one-cycle clear pulse
	output logic [`DRS_CS_W-1:0] clock_check_count // last measured count
);
	localparam logic [`DRS_SUP_WIN_W-1:0] WIN_LAST =
		`DRS_SUP_WIN_W'(WINDOW_CYC - 1);
	localparam logic [`DRS_CS_W-1:0] CNT_MAX = '1;

	logic osc_s1_r;
	logic osc_s2_r;
	logic osc_s3_r;
	logic [`DRS_SUP_WIN_W-1:0] win_r;
	logic [`DRS_CS_W-1:0] edges_r;
	logic [`DRS_CS_W-1:0] count_r;
	drs_pkg::drs_sup_state_type state_r;
	drs_pkg::drs_sup_state_type state_nxt;

	wire osc_rise = osc_s2_r & ~osc_s3_r;
	wire win_end = (win_r == WIN_LAST);
	// saturate so a runaway oscillator reads as full scale, not a wrap
	wire edges_full = (edges_r == CNT_MAX);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end
		else
		begin
			osc_s1_r <= primary_oscillator;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			drs_pkg::DRS_SUP_IDLE: state_nxt = drs_pkg::DRS_SUP_COUNT;
			drs_pkg::DRS_SUP_COUNT:
				if (win_end)
					state_nxt = drs_pkg::DRS_SUP_STORE;
			drs_pkg::DRS_SUP_STORE: state_nxt = drs_pkg::DRS_SUP_COUNT;
			default: state_nxt = drs_pkg::DRS_SUP_IDLE;
		endcase
		if (primary_count_clear)
			state_nxt = drs_pkg::DRS_SUP_IDLE;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r <= drs_pkg::DRS_SUP_IDLE;
			win_r <= '0;
			edges_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r != drs_pkg::DRS_SUP_COUNT || primary_count_clear)
			begin
				win_r <= '0;
				edges_r <= '0;
			end
			else
			begin
				win_r <= win_r + 1'b1;
				if (osc_rise && !edges_full)
					edges_r <= edges_r + 1'b1;
			end
		end
	end

	// only hardware loads the count; the clear pulse zeroes it
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			count_r <= '0;
		else if (primary_count_clear)
			count_r <= '0;
		else if (state_r == drs_pkg::DRS_SUP_STORE)
			count_r <= edges_r;
	end

	assign clock_check_count = count_r;
endmodule
`default_nettype wire

/* drs_status_readback.sv */
// status readback registers of the isolated gate driver secondary
`timescale 1ns/1ns
`default_nettype none
`include "drs_defs.svh"
module drs_status_readback #(
	// arbitrary neutral version code
	parameter logic [`DRS_VER_W-1:0] SEC_VERSION = 12'h3c7,
	parameter int WINDOW_CYC = `DRS_SUP_WINDOW_CYC
)(
	input wire logic clk, // system clock, 10 MHz
	input wire logic sys_rst, // async reset, active high
	input wire logic rd_req, // one-cycle read request
	input wire drs_pkg::drs_addr_type rd_addr, // register offset
	output logic [15:0] rd_data, // response word
	output logic rd_valid, // response strobe
	input wire logic msg_done, // frame finished, one-cycle
	input wire logic msg_discard, // that frame was discarded
	input wire logic primary_oscillator, // raw oscillator pin
	input wire logic primary_count_clear, // count clear pulse
	input wire logic overtemp_flag, // overtemperature detector
	input wire logic output_tristate_flag, // output stage tristated
	input wire logic overcurrent_detect, // over threshold comparator
	input wire logic overcurrent_clear, // sticky clear pulse
	input wire logic debug_active_flag, // debug mode active
	input wire logic [`DRS_MODE_W-1:0] operating_mode_code, // mode
	input wire logic class_b_event_flag, // class B conditions met
	input wire logic class_a_event_flag, // class A conditions met
	input wire logic pwm_command // received PWM command, 1 = on
);
	logic [`DRS_PIN_N-1:0] pin_raw;
	logic [`DRS_PIN_N-1:0] pin_s1_r;
	logic [`DRS_PIN_N-1:0] pin_s2_r;
	logic ocp_sticky_r;
	logic ocp_sticky_nxt;
	logic msg_inv_r;
	logic [15:0] rd_data_r;
	logic [15:0] rd_data_nxt;
	logic rd_valid_r;
	logic [`DRS_CS_W-1:0] clock_check_count;

	// body is bits 15:2; appends message flag and parity bit
	function automatic drs_pkg::drs_word_type make_word(
		input logic [15:2] body,
		input logic msg_inv
	);
		logic par;
		par = ~(^{body, msg_inv});
		make_word = {body, msg_inv, par};
	endfunction

	drs_clock_check #(
		.WINDOW_CYC(WINDOW_CYC)
	) u_clock_check (
		.clk(clk),
		.sys_rst(sys_rst),
		.primary_oscillator(primary_oscillator),
		.primary_count_clear(primary_count_clear),
		.clock_check_count(clock_check_count)
	);

	assign pin_raw[`DRS_PIN_OVERTEMP] = overtemp_flag;
	assign pin_raw[`DRS_PIN_TRISTATE] = output_tristate_flag;
	assign pin_raw[`DRS_PIN_OCP] = overcurrent_detect;
	assign pin_raw[`DRS_PIN_DEBUG] = debug_active_flag;
	assign pin_raw[`DRS_PIN_CLASS_B] = class_b_event_flag;
	assign pin_raw[`DRS_PIN_CLASS_A] = class_a_event_flag;
	assign pin_raw[`DRS_PIN_PWM] = pwm_command;

	// analog and cross-chip flag levels: two flops before any use; operating_mode_code is read without them
	genvar gi;
	generate
		for (gi = 0; gi < `DRS_PIN_N; gi++)
		begin : g_sync
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					pin_s1_r[gi] <= 1'b0;
					pin_s2_r[gi] <= 1'b0;
				end
				else
				begin
					pin_s1_r[gi] <= pin_raw[gi];
					pin_s2_r[gi] <= pin_s1_r[gi];
				end
			end
		end
	endgenerate

	// set wins over clear so a detection during the clear is kept
	assign ocp_sticky_nxt = pin_s2_r[`DRS_PIN_OCP] |
		(ocp_sticky_r & ~overcurrent_clear);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ocp_sticky_r <= 1'b0;
		else
			ocp_sticky_r <= ocp_sticky_nxt;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			msg_inv_r <= 1'b0;
		else if (msg_done)
			msg_inv_r <= msg_discard;
	end

	wire [15:2] body_clk_sup = {clock_check_count, 6'h00};
	wire [15:2] body_sec_id = {SEC_VERSION, 2'b00};
	wire [15:2] body_sec_stat = {
		2'b00,
		pin_s2_r[`DRS_PIN_OVERTEMP],
		pin_s2_r[`DRS_PIN_TRISTATE],
		ocp_sticky_r,
		pin_s2_r[`DRS_PIN_DEBUG],
		operating_mode_code,
		pin_s2_r[`DRS_PIN_CLASS_B],
		pin_s2_r[`DRS_PIN_CLASS_A],
		pin_s2_r[`DRS_PIN_PWM],
		2'b00
	};

	wire sel_clk_sup = (rd_addr == `DRS_OFS_CLK_SUP);
	wire sel_sec_id = (rd_addr == `DRS_OFS_SEC_ID);
	wire sel_sec_stat = (rd_addr == `DRS_OFS_SEC_STAT);
	// unmapped offsets answer an all-zero body, still with flag and parity
	wire [15:2] body_sel = sel_clk_sup ? body_clk_sup :
		sel_sec_id ? body_sec_id :
		sel_sec_stat ? body_sec_stat : 14'h0000;

	assign rd_data_nxt = rd_req ? make_word(body_sel, msg_inv_r) : rd_data_r;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_data_r <= `DRS_RST_SEC_STAT;
			rd_valid_r <= 1'b0;
		end
		else
		begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_req;
		end
	end

	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
endmodule
`default_nettype wire

/* drs_status_readback_checker.sv */
// assertions on the status readback ports
`timescale 1ns/1ns
`default_nettype none
module drs_status_readback_checker #(
	parameter logic [11:0] SEC_VERSION = 12'h3c7
)(
	input wire logic clk, // clock
	input wire logic sys_rst, // reset
	input wire logic rd_req, // request
	input wire drs_pkg::drs_addr_type rd_addr, // offset
	input wire logic [15:0] rd_data, // word
	input wire logic rd_valid, // strobe
	input wire logic msg_done, // frame end
	input wire logic msg_discard, // discarded
	input wire logic primary_count_clear, // clear
	input wire logic overtemp_flag, // overtemp
	input wire logic [2:0] operating_mode_code // mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic st = rd_req && rd_addr == 7'h11;
	msg_flag_a: assert property (
		msg_done ##1 !msg_done ##1 rd_req && !msg_done
		|=> rd_data[1] == $past(msg_discard, 3))
		else $error("message flag bad");
	odd_parity_a: assert property (
		rd_valid |-> ^rd_data) else $error("parity bad");
	id_code_a: assert property (
		rd_req && rd_addr == 7'h10
		|=> rd_data[15:2] == {SEC_VERSION, 2'b00}) else $error("id bad");
	cs_res_a: assert property (
		rd_req && rd_addr == 7'h0b |=> rd_data[7:2] == 6'h00)
		else $error("count word bad");
	count_clear_a: assert property (
		primary_count_clear ##2 rd_req && rd_addr == 7'h0b
		|=> rd_data[15:8] == 8'h00) else $error("clear bad");
	stat_res_a: assert property (
		st |=> rd_valid && rd_data[15:14] == 2'b00 && rd_data[3:2] == 2'b00)
		else $error("status reserved bad");
	op_mode_a: assert property (
		st && $stable(operating_mode_code)
		|=> rd_data[9:7] == $past(operating_mode_code)) else $error("mode bad");
	overtemp_a: assert property (
		st && $stable(overtemp_flag) && $past(overtemp_flag, 2) == overtemp_flag
		&& $past(overtemp_flag, 3) == overtemp_flag
		|=> rd_data[13] == $past(overtemp_flag)) else $error("overtemp bad");
endmodule
bind drs_status_readback drs_status_readback_checker #(
	.SEC_VERSION(SEC_VERSION)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
	.rd_valid(rd_valid), .msg_done(msg_done), .msg_discard(msg_discard),
	.primary_count_clear(primary_count_clear),
	.overtemp_flag(overtemp_flag), .operating_mode_code(operating_mode_code));
`default_nettype wire

/* drs_host_model.sv */
// host side model issuing reads and count clears
`timescale 1ns/1ns
`default_nettype none
module drs_host_model (
	input wire logic clk, // clock
	input wire logic rd_valid, // strobe
	input wire logic [15:0] rd_data, // word
	output logic rd_req, // request
	output var drs_pkg::drs_addr_type rd_addr, // offset
	output logic primary_count_clear // clear
);
	initial
	begin
		rd_req = 1'b0;
		rd_addr = 7'h00;
		primary_count_clear = 1'b0;
	end
	task automatic read(input drs_pkg::drs_addr_type a,
		output logic [15:0] d, output logic v);
	begin
		@(negedge clk);
		rd_req = 1'b1;
		rd_addr = a;
		@(negedge clk);
		rd_req = 1'b0;
		rd_addr = ~a; // no stale offset after release
		v = rd_valid;
		d = rd_data;
	end
	endtask
	task automatic clear();
	begin
		@(negedge clk);
		primary_count_clear = 1'b1;
		@(negedge clk);
		primary_count_clear = 1'b0;
	end
	endtask
endmodule
`default_nettype wire

/* drs_status_readback_tb.sv */
// testbench of the status readback block
`timescale 1ns/1ns
`default_nettype none
module drs_status_readback_tb;
	localparam logic [11:0] VER = 12'h3c7; // arbitrary code
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rd_req, rd_valid, clr;
	logic msg_done = 1'b0, msg_discard = 1'b0, ocp_clr = 1'b0;
	logic [1:0] osc = 2'b00;
	logic [13:4] pin = 10'h000; // laid out like the status word
	drs_pkg::drs_addr_type rd_addr;
	logic [15:0] rd_data;
	int n_tests = 0, n_mismatch = 0;
	initial forever #50 clk = ~clk;
	always @(negedge clk) osc <= osc + 2'd1; // period of four cycles
	drs_status_readback #(.SEC_VERSION(VER), .WINDOW_CYC(16))
		u_drs_status_readback (.clk(clk), .sys_rst(sys_rst),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
		.rd_valid(rd_valid), .msg_done(msg_done), .msg_discard(msg_discard),
		.primary_oscillator(osc[1]), .primary_count_clear(clr),
		.overtemp_flag(pin[13]), .output_tristate_flag(pin[12]),
		.overcurrent_detect(pin[11]), .overcurrent_clear(ocp_clr),
		.debug_active_flag(pin[10]), .operating_mode_code(pin[9:7]),
		.class_b_event_flag(pin[6]), .class_a_event_flag(pin[5]),
		.pwm_command(pin[4]));
	drs_host_model u_drs_host_model (.clk(clk), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_req(rd_req), .rd_addr(rd_addr),
		.primary_count_clear(clr));
	task automatic chk(input drs_pkg::drs_addr_type a,
		input logic [15:2] b, input logic l);
		logic [15:0] d, e;
		logic v;
	begin
		e = {b, l, ~^{b, l}};
		u_drs_host_model.read(a, d, v);
		n_tests++;
		if (v !== 1'b1 || d !== e)
		begin
			n_mismatch++;
			$display("[ERR] word %h: expected %h seen %h", a, e, d);
		end
	end
	endtask
	task automatic summarize();
	begin
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		n_tests++;
		if (rd_data !== 16'h0001 || rd_valid !== 1'b0)
		begin
			n_mismatch++;
			$display("[ERR] reset word: expected 0001 seen %h", rd_data);
		end
		chk(7'h0b, 14'h0000, 1'b0);
		chk(7'h10, {VER, 2'b00}, 1'b0);
		chk(7'h11, 14'h0000, 1'b0);
		chk(7'h2a, 14'h0000, 1'b0);
		$display("test reset done");
		for (int k = 4; k < 14; k++)
		begin
			pin[k] = (k != 11);
			repeat (3) @(negedge clk);
			chk(7'h11, {2'b00, pin, 2'b00}, 1'b0);
			pin[k] = 1'b0;
		end
		for (int m = 0; m < 8; m++)
		begin
			pin[9:7] = m[2:0];
			repeat (3) @(negedge clk);
			chk(7'h11, {2'b00, pin, 2'b00}, 1'b0);
		end
		pin[9:7] = 3'd0;
		$display("test status done");
		pin[11] = 1'b1;
		@(negedge clk);
		pin[11] = 1'b0; // brief excursion must still stick
		repeat (3) @(negedge clk);
		chk(7'h11, 14'h0200, 1'b0);
		chk(7'h11, 14'h0200, 1'b0);
		ocp_clr = 1'b1;
		@(negedge clk);
		ocp_clr = 1'b0;
		chk(7'h11, 14'h0000, 1'b0);
		pin[11] = 1'b1;
		@(negedge clk);
		pin[11] = 1'b0;
		@(negedge clk);
		ocp_clr = 1'b1; // lands with the detection: set must win
		@(negedge clk);
		ocp_clr = 1'b0;
		chk(7'h11, 14'h0200, 1'b0);
		ocp_clr = 1'b1;
		@(negedge clk);
		ocp_clr = 1'b0;
		chk(7'h11, 14'h0000, 1'b0);
		$display("test sticky done");
		msg_done = 1'b1;
		msg_discard = 1'b1;
		@(negedge clk);
		msg_done = 1'b0;
		chk(7'h10, {VER, 2'b00}, 1'b1);
		chk(7'h0b, 14'h0100, 1'b1);
		u_drs_host_model.clear();
		chk(7'h0b, 14'h0000, 1'b1);
		msg_done = 1'b1;
		msg_discard = 1'b0;
		@(negedge clk);
		msg_done = 1'b0;
		chk(7'h11, 14'h0000, 1'b0);
		$display("test message and count done");
		summarize();
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule
`default_nettype wire
